// >>> rtl/mdar_regs.sv
// Monitor data and alarm register bank: results, output codes, limit alarms.
// Assumes results come from same-clock converter logic as one-cycle strobes
// and that software uses the plain byte register port.
`timescale 1ns/10ps
`default_nettype none

module mdar_regs (
    // Clock and reset
    input  wire logic                                  core_clk,
    input  wire logic                                  rst,
    // Register port
    input  wire logic [mdar_pkg::ADDR_W-1:0]           reg_addr,
    input  wire logic [mdar_pkg::DATA_W-1:0]           reg_wdata,
    input  wire logic                                  reg_wr,
    input  wire logic                                  reg_rd,
    output var  logic [mdar_pkg::DATA_W-1:0]           reg_rdata,
    // Converter results
    input  wire logic                                  conv_valid,
    input  wire logic [mdar_pkg::CH_W-1:0]             conv_chan,
    input  wire logic [mdar_pkg::RES_W-1:0]            conversion_result_field,
    input  wire logic                                  temp_valid,
    input  wire logic [mdar_pkg::RES_W-1:0]            temp_result,
    // Output channel codes
    output var  logic [mdar_pkg::OUT_CHANS-1:0][mdar_pkg::RES_W-1:0] output_code_field,
    output var  logic                                  out_load,
    output var  logic [mdar_pkg::OUT_CH_W-1:0]         out_load_chan,
    // Alarms and interrupt
    output var  logic                                  alarm_output_pin,
    output var  logic                                  irq
);
    import mdar_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [RES_W-1:0]     adc_q [0:ADC_CHANS-1];
    logic [RES_W-1:0]     temp_q;
    logic [DATA_W-1:0]    thr_q [0:THR_BYTES-1];
    logic                 latch_dis_q;
    logic [ALM_CHANS-1:0] src_q;
    logic [NEED_W-1:0]    need_q;
    logic [IRQ_W-1:0]     irq_stat_q;
    logic [IRQ_W-1:0]     irq_stat_d;
    logic [IRQ_W-1:0]     irq_mask_q;
    logic [ALM_CHANS-1:0] flags;
    logic [ALM_CHANS-1:0] raises;
    logic [DATA_W-1:0]    rd_d;
    logic [ADDR_W-1:0]    adc_off;
    logic [ADDR_W-1:0]    out_off;
    logic [ADDR_W-1:0]    thr_off;
    logic                 in_adc;
    logic                 in_out;
    logic                 in_thr;
    logic                 alarm_rd;
    logic                 irq_rd;

    assign adc_off  = reg_addr - ADC_BASE;
    assign out_off  = reg_addr - OUT_BASE;
    assign thr_off  = reg_addr - THR_BASE;
    assign in_adc   = (reg_addr >= ADC_BASE) && (reg_addr <= ADC_LAST);
    assign in_out   = (reg_addr >= OUT_BASE) && (reg_addr <= OUT_LAST);
    assign in_thr   = (reg_addr >= THR_BASE) && (reg_addr <= THR_LAST);
    assign alarm_rd = reg_rd && (reg_addr == ALARM_STAT);
    assign irq_rd   = reg_rd && (reg_addr == IRQ_STAT);

    // ------------------------------------------------------------
    // Converter and temperature results
    // ------------------------------------------------------------
    // Stored as delivered: inputs are unsigned, temperature is signed
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < ADC_CHANS; i++) begin
                adc_q[i] <= RES_ZERO;
            end
        end else if (conv_valid && (conv_chan < CH_W'(ADC_CHANS))) begin
            adc_q[conv_chan] <= conversion_result_field;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            temp_q <= RES_ZERO;
        end else if (temp_valid) begin
            temp_q <= temp_result;
        end
    end

    // ------------------------------------------------------------
    // Output codes
    // ------------------------------------------------------------
    // Bytes update separately; a code passes through a mixed value between writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            output_code_field <= '0;
        end else if (reg_wr && in_out) begin
            if (!out_off[0]) begin
                output_code_field[out_off[4:1]][7:0] <= reg_wdata;
            end else begin
                output_code_field[out_off[4:1]][11:8] <= reg_wdata[3:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_load      <= 1'b0;
            out_load_chan <= '0;
        end else begin
            out_load <= reg_wr && in_out;
            if (reg_wr && in_out) begin
                out_load_chan <= out_off[4:1];
            end
        end
    end

    // ------------------------------------------------------------
    // Alarm settings
    // ------------------------------------------------------------
    // Upper limits reset to full scale so nothing alarms before set-up
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < THR_BYTES; i++) begin
                thr_q[i] <= ((i % 4) >= 2) ? THR_HI_RST : THR_LO_RST;
            end
        end else if (reg_wr && in_thr) begin
            thr_q[thr_off[4:0]] <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            latch_dis_q <= 1'b0;
            src_q       <= SRC_RST;
            need_q      <= NEED_RST;
            irq_mask_q  <= IRQ_RST;
        end else if (reg_wr) begin
            if (reg_addr == CFG_ADDR) begin
                latch_dis_q <= reg_wdata[LATCH_DIS_BIT];
            end
            if (reg_addr == SRC_ADDR) begin
                src_q <= reg_wdata[ALM_CHANS-1:0];
            end
            if (reg_addr == NEED_ADDR) begin
                need_q <= reg_wdata[NEED_W-1:0];
            end
            if (reg_addr == IRQ_MASK) begin
                irq_mask_q <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Limit-checked channels 16 to 20
    // ------------------------------------------------------------
    for (genvar g = 0; g < ALM_CHANS; g++) begin : g_alarm
        mdar_alarm_chan u_chan (
            .core_clk  (core_clk),
            .rst       (rst),
            .sample_en (conv_valid && (conv_chan == ALM_FIRST_CH + CH_W'(g))),
            .result    (conversion_result_field),
            .lo_thr    ({thr_q[4*g+1][3:0], thr_q[4*g]}),
            .hi_thr    ({thr_q[4*g+3][3:0], thr_q[4*g+2]}),
            .need_set  (need_q),
            .latch_dis (latch_dis_q),
            .read_clr  (alarm_rd),
            .flag_q    (flags[g]),
            .raise     (raises[g])
        );
    end

    // Pin follows the already latched flags selected by a zero source bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            alarm_output_pin <= 1'b0;
        end else begin
            alarm_output_pin <= |(flags & ~src_q);
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and line
    // ------------------------------------------------------------
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (irq_rd) begin
            irq_stat_d = IRQ_RST;
        end
        if (|raises) begin
            irq_stat_d[IRQ_ALARM_BIT] = 1'b1;
        end
        if (conv_valid) begin
            irq_stat_d[IRQ_CONV_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= IRQ_RST;
            irq        <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq        <= |(irq_stat_d & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rd_d = BYTE_ZERO;
        if (in_adc) begin
            if (!adc_off[0]) begin
                rd_d = adc_q[adc_off[5:1]][7:0];
            end else begin
                rd_d = {NIB_ZERO, adc_q[adc_off[5:1]][11:8]};
            end
        end else if (reg_addr == TEMP_LO) begin
            rd_d = temp_q[7:0];
        end else if (reg_addr == TEMP_HI) begin
            rd_d = {NIB_ZERO, temp_q[11:8]};
        end else if (in_out) begin
            if (!out_off[0]) begin
                rd_d = output_code_field[out_off[4:1]][7:0];
            end else begin
                rd_d = {NIB_ZERO, output_code_field[out_off[4:1]][11:8]};
            end
        end else if (reg_addr == ALARM_STAT) begin
            rd_d = {STAT_RSV, flags};
        end else if (in_thr) begin
            if (!thr_off[0]) begin
                rd_d = thr_q[thr_off[4:0]];
            end else begin
                rd_d = {NIB_ZERO, thr_q[thr_off[4:0]][3:0]};
            end
        end else if (reg_addr == CFG_ADDR) begin
            rd_d[LATCH_DIS_BIT] = latch_dis_q;
        end else if (reg_addr == SRC_ADDR) begin
            rd_d[ALM_CHANS-1:0] = src_q;
        end else if (reg_addr == NEED_ADDR) begin
            rd_d[NEED_W-1:0] = need_q;
        end else if (reg_addr == IRQ_STAT) begin
            rd_d[IRQ_W-1:0] = irq_stat_q;
        end else if (reg_addr == IRQ_MASK) begin
            rd_d[IRQ_W-1:0] = irq_mask_q;
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= BYTE_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end else begin
            reg_rdata <= BYTE_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [RES_W-1:0] adc0_w;
    assign adc0_w = adc_q[0];

    adc_low_read_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == ADC_BASE |=> reg_rdata == $past(adc0_w[7:0]))
        else $error("channel 0 low byte read wrong");

    adc_high_rsv_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && in_adc && adc_off[0] |=> reg_rdata[7:4] == NIB_ZERO)
        else $error("result high byte reserved bits set");

    adc_store_a: assert property (@(posedge core_clk) disable iff (rst)
        conv_valid && conv_chan == '0 |=> adc0_w == $past(conversion_result_field))
        else $error("result not stored unchanged");

    temp_low_a: assert property (@(posedge core_clk) disable iff (rst)
        temp_valid ##1 reg_rd && reg_addr == TEMP_LO && !temp_valid
        |=> reg_rdata == $past(temp_result[7:0], 2))
        else $error("temperature low byte wrong");

    temp_high_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == TEMP_HI |=> reg_rdata[7:4] == NIB_ZERO)
        else $error("temperature high byte reserved bits set");

    out_code_wr_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == OUT_BASE
        |=> output_code_field[0][7:0] == $past(reg_wdata) && out_load && out_load_chan == '0)
        else $error("output code byte not stored or not loaded");

    status_rsv_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == ALARM_STAT |=> reg_rdata[7:5] == STAT_RSV)
        else $error("status reserved bits set");

    status_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        alarm_rd && !conv_valid && !latch_dis_q |=> flags == '0)
        else $error("status read did not clear the flags");

    pin_follow_a: assert property (@(posedge core_clk) disable iff (rst)
        |(flags & ~src_q) |=> alarm_output_pin)
        else $error("alarm pin not raised by a selected flag");

    irq_level_a: assert property (@(posedge core_clk) disable iff (rst)
        irq == |(irq_stat_q & $past(irq_mask_q)))
        else $error("interrupt line disagrees with unmasked status");

    status_read_a: assert property (@(posedge core_clk) disable iff (rst)
        alarm_rd |=> reg_rdata[ALM_CHANS-1:0] == $past(flags))
        else $error("status byte does not show the flags");

    rdata_idle_a: assert property (@(posedge core_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == BYTE_ZERO)
        else $error("read data outside the cycle after a read");

    temp_store_a: assert property (@(posedge core_clk) disable iff (rst)
        temp_valid |=> temp_q == $past(temp_result))
        else $error("temperature not stored unchanged");

    temp_ro_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == TEMP_LO && !temp_valid |=> temp_q == $past(temp_q))
        else $error("write changed the temperature");

    adc_ro_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == ADC_BASE && !conv_valid |=> adc0_w == $past(adc0_w))
        else $error("write changed a result");

    out_hi_rsv_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && in_out && out_off[0] |=> reg_rdata[7:4] == NIB_ZERO)
        else $error("output code high byte reserved bits set");

    irq_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        irq_rd && !conv_valid && !(|raises) |=> irq_stat_q == IRQ_RST)
        else $error("interrupt status not cleared by its read");

    pin_src_a: assert property (@(posedge core_clk) disable iff (rst)
        (flags & ~src_q) == '0 |=> !alarm_output_pin)
        else $error("alarm pin raised without a selected flag");

    unmapped_rd_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr > IRQ_MASK |=> reg_rdata == BYTE_ZERO)
        else $error("unmapped address read nonzero");

    flag_set_c: cover property (@(posedge core_clk) disable iff (rst) |raises);
    read_clr_c: cover property (@(posedge core_clk) disable iff (rst) alarm_rd && |flags);
    pin_c:      cover property (@(posedge core_clk) disable iff (rst) alarm_output_pin);
    irq_c:      cover property (@(posedge core_clk) disable iff (rst) irq ##1 irq_rd);
    load_c:     cover property (@(posedge core_clk) disable iff (rst) out_load);

endmodule

`default_nettype wire

// >>> rtl/mdar_pkg.sv
// Constants for the monitor data and alarm register bank.
// Assumes a single 10 MHz core clock and a byte-wide register port.

package mdar_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 8;
    localparam int RES_W     = 12;
    localparam int CH_W      = 5;
    localparam int OUT_CH_W  = 4;
    localparam int NEED_W    = 3;
    localparam int RUN_W     = 4;
    localparam int IRQ_W     = 2;

    // ------------------------------------------------------------
    // Channel counts
    // ------------------------------------------------------------
    localparam int ADC_CHANS = 21;
    localparam int OUT_CHANS = 16;
    localparam int ALM_CHANS = 5;
    localparam int THR_BYTES = 20;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADC_BASE   = 8'h20;
    localparam logic [ADDR_W-1:0] ADC_LAST   = 8'h49;
    localparam logic [ADDR_W-1:0] TEMP_LO    = 8'h4A;
    localparam logic [ADDR_W-1:0] TEMP_HI    = 8'h4B;
    localparam logic [ADDR_W-1:0] OUT_BASE   = 8'h50;
    localparam logic [ADDR_W-1:0] OUT_LAST   = 8'h6F;
    localparam logic [ADDR_W-1:0] ALARM_STAT = 8'h70;
    localparam logic [ADDR_W-1:0] THR_BASE   = 8'h80;
    localparam logic [ADDR_W-1:0] THR_LAST   = 8'h93;
    localparam logic [ADDR_W-1:0] CFG_ADDR   = 8'h94;
    localparam logic [ADDR_W-1:0] SRC_ADDR   = 8'h95;
    localparam logic [ADDR_W-1:0] NEED_ADDR  = 8'h96;
    localparam logic [ADDR_W-1:0] IRQ_STAT   = 8'h97;
    localparam logic [ADDR_W-1:0] IRQ_MASK   = 8'h98;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int LATCH_DIS_BIT = 4;
    localparam int IRQ_ALARM_BIT = 0;
    localparam int IRQ_CONV_BIT  = 1;
    localparam logic [CH_W-1:0]     ALM_FIRST_CH = 5'h10;
    localparam logic [DATA_W-1:0]   BYTE_ZERO    = 8'h00;
    localparam logic [3:0]          NIB_ZERO     = 4'h0;
    localparam logic [2:0]          STAT_RSV     = 3'h0;
    localparam logic [RES_W-1:0]    RES_ZERO     = 12'h000;
    localparam logic [DATA_W-1:0]   THR_LO_RST   = 8'h00;
    localparam logic [DATA_W-1:0]   THR_HI_RST   = 8'hFF;
    localparam logic [ALM_CHANS-1:0] SRC_RST     = 5'h00;
    localparam logic [NEED_W-1:0]   NEED_RST     = 3'h0;
    localparam logic [IRQ_W-1:0]    IRQ_RST      = 2'h0;
    localparam logic [RUN_W-1:0]    RUN_ZERO     = 4'h0;
    localparam logic [RUN_W-1:0]    RUN_MAX      = 4'hF;
    localparam logic [RUN_W-1:0]    RUN_ONE      = 4'h1;

endpackage

// >>> rtl/mdar_alarm_chan.sv
// One limit-checked alarm channel: run counter and status flag.
// Assumes results arrive as single-cycle strobes from same-clock logic.
`timescale 1ns/10ps
`default_nettype none

module mdar_alarm_chan (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    // Result and window
    input  wire logic                          sample_en,
    input  wire logic [mdar_pkg::RES_W-1:0]    result,
    input  wire logic [mdar_pkg::RES_W-1:0]    lo_thr,
    input  wire logic [mdar_pkg::RES_W-1:0]    hi_thr,
    // Settings
    input  wire logic [mdar_pkg::NEED_W-1:0]   need_set,
    input  wire logic                          latch_dis,
    input  wire logic                          read_clr,
    // Flag
    output var  logic                          flag_q,
    output logic                               raise
);
    import mdar_pkg::*;

    logic [RUN_W-1:0] run_q;
    logic [RUN_W-1:0] run_d;
    logic [RUN_W-1:0] need;
    logic             oor;
    logic             cond_d;
    logic             flag_d;

    // ------------------------------------------------------------
    // Window check and run of out-of-range results
    // ------------------------------------------------------------
    assign need = {1'b0, need_set} + RUN_ONE;
    assign oor  = (result < lo_thr) || (result > hi_thr);

    always_comb begin
        run_d = run_q;
        if (sample_en) begin
            if (!oor) begin
                run_d = RUN_ZERO;
            end else if (run_q != RUN_MAX) begin
                run_d = run_q + RUN_ONE;
            end
        end
    end

    assign cond_d = (run_d >= need);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            run_q <= RUN_ZERO;
        end else begin
            run_q <= run_d;
        end
    end

    // ------------------------------------------------------------
    // Flag: a new result wins over a read in the same cycle
    // ------------------------------------------------------------
    always_comb begin
        if (latch_dis) begin
            flag_d = cond_d;
        end else if (sample_en && cond_d) begin
            flag_d = 1'b1;
        end else if (read_clr) begin
            flag_d = 1'b0;
        end else begin
            flag_d = flag_q;
        end
    end

    assign raise = flag_d & ~flag_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    run_reset_a: assert property (@(posedge core_clk) disable iff (rst)
        sample_en && !oor |=> run_q == RUN_ZERO)
        else $error("run not reset by an in-range result");

    flag_run_a: assert property (@(posedge core_clk) disable iff (rst)
        !latch_dis && !flag_q ##1 flag_q |-> run_q >= need)
        else $error("flag set before N results in a row");

    flag_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        flag_q && !read_clr && !latch_dis |=> flag_q)
        else $error("latched flag dropped without a read");

    follow_a: assert property (@(posedge core_clk) disable iff (rst)
        latch_dis && sample_en && !oor |=> !flag_q)
        else $error("unlatched flag stayed after recovery");

endmodule

`default_nettype wire

// >>> test/mdar_conv_model.sv
// Converter model: one result strobe per request.
// Assumes the bench raises go for one core_clk cycle.
`timescale 1ns/10ps
`default_nettype none
module mdar_conv_model (
    // Clock and request
    input  wire logic        core_clk,
    input  wire logic        go,
    input  wire logic [4:0]  chan,
    input  wire logic [11:0] value,
    // Result strobe
    output var  logic        conv_valid,
    output var  logic [4:0]  conv_chan,
    output var  logic [11:0] conversion_result_field
);
    // Idle lines invert so stale data never looks valid
    always_ff @(posedge core_clk) begin
        conv_valid              <= go;
        conv_chan               <= go ? chan : ~conv_chan;
        conversion_result_field <= go ? value : ~conversion_result_field;
    end
endmodule
`default_nettype wire

// >>> test/test_mdar_regs.sv
// Self-checking bench for the monitor data and alarm register bank.
// Assumes the package, the bank and the converter model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module test_mdar_regs;
    import mdar_pkg::*;
    logic        core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, go = 0, temp_valid = 0;
    logic        rd_pend = 0, conv_valid, out_load, alarm_output_pin, irq;
    logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, exp_r, exp_q[$];
    logic [4:0]  chan = 0, conv_chan;
    logic [3:0]  out_load_chan;
    logic [11:0] value = 0, temp_result = 0, conversion_result_field, rv;
    logic [OUT_CHANS-1:0][RES_W-1:0] output_code_field;
    int          bad_count = 0, checks = 0, seed = 51, loads = 0;

    initial forever #50 core_clk = ~core_clk;
    mdar_conv_model src (.core_clk, .go, .chan, .value, .conv_valid, .conv_chan,
        .conversion_result_field);
    mdar_regs uut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .conv_valid, .conv_chan, .conversion_result_field, .temp_valid, .temp_result,
        .output_code_field, .out_load, .out_load_chan, .alarm_output_pin, .irq);

    // --------------------------------
    // Bus tasks and read monitor
    // --------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= d; end
        @(posedge core_clk) reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk) begin reg_rd <= 1; reg_addr <= a; exp_q.push_back(e); end
        @(posedge core_clk) reg_rd <= 0;
    endtask
    task automatic conv(input logic [11:0] v);
        @(posedge core_clk) begin go <= 1; chan <= 5'd16; value <= v; end
        @(posedge core_clk) go <= 0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic summarize;
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) rd_pend <= reg_rd;
    always @(negedge core_clk) if (out_load === 1'b1) loads++;
    always @(negedge core_clk) begin
        if (rd_pend) begin
            exp_r = exp_q.pop_front();
            `CHK(reg_rdata, exp_r)
        end
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        bad_count++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 0;
        rd(8'h70, 8'h00);
        rd(8'h4A, 8'h00);
        rd(8'h55, 8'h00);
        rd(8'hA0, 8'h00);
        wr(8'h20, 8'hA5);
        rd(8'h20, 8'h00);
        wr(8'h50, 8'h5A);
        rd(8'h50, 8'h5A);
        rv = 12'($random(seed));
        wr(8'h52, rv[7:0]);
        wr(8'h53, 8'hFF);
        rd(8'h52, rv[7:0]);
        rd(8'h53, 8'h0F);
        `CHK(output_code_field[1], {4'hF, rv[7:0]})
        `CHK(out_load_chan, 4'd1)
        `CHK(loads, 3)
        rv = 12'($random(seed));
        @(posedge core_clk) begin go <= 1; chan <= 5'd3; value <= rv; end
        @(posedge core_clk) go <= 0;
        wr(8'h26, ~rv[7:0]);
        rd(8'h26, rv[7:0]);
        rd(8'h27, {4'h0, rv[11:8]});
        @(posedge core_clk) begin temp_valid <= 1; temp_result <= 12'hF9C; end
        @(posedge core_clk) temp_valid <= 0;
        rd(8'h4A, 8'h9C);
        rd(8'h4B, 8'h0F);
        // Channel 16 window top 0x8FF, two misses in a row needed
        wr(8'h83, 8'h08);
        wr(8'h96, 8'h01);
        wr(8'h98, 8'h01);
        conv(12'h900);
        conv(12'h100);
        conv(12'h900);
        rd(8'h70, 8'h00);
        conv(12'h900);
        conv(12'h100);
        @(negedge core_clk);
        `CHK(alarm_output_pin, 1'b1)
        `CHK(irq, 1'b1)
        rd(8'h97, 8'h03);
        @(negedge core_clk);
        `CHK(irq, 1'b0)
        rd(8'h70, 8'h01);
        rd(8'h70, 8'h00);
        conv(12'h900);
        conv(12'h900);
        rd(8'h70, 8'h01);
        conv(12'h900);
        rd(8'h70, 8'h01);
        conv(12'h900);
        wr(8'h94, 8'h10);
        conv(12'h100);
        repeat (2) @(negedge core_clk);
        `CHK(alarm_output_pin, 1'b0)
        wr(8'h94, 8'h00);
        conv(12'h900);
        conv(12'h900);
        @(negedge core_clk);
        `CHK(alarm_output_pin, 1'b1)
        wr(8'h95, 8'h01);
        repeat (2) @(negedge core_clk);
        `CHK(alarm_output_pin, 1'b0)
        @(posedge core_clk) rst <= 1;
        @(posedge core_clk) rst <= 0;
        rd(8'h70, 8'h00);
        repeat (2) @(posedge core_clk);
        summarize();
    end
endmodule
`default_nettype wire
